// ### design/lsit_pkg.sv
// lsit_pkg: constants shared by the light sensor two-wire trim port.
// assumes a single design file imports it whole; no timing beyond counts.
package lsit_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_STATUS     = 8'h00;
    localparam logic [7:0] REG_MAIN_CFG   = 8'h01;
    localparam logic [7:0] REG_RX_CFG     = 8'h02;
    localparam logic [7:0] REG_RESULT_HI  = 8'h04;
    localparam logic [7:0] REG_RESULT_LO  = 8'h05;
    localparam logic [7:0] REG_GREEN_TRIM = 8'h0f;
    localparam logic [7:0] REG_IR_TRIM_HI = 8'h10;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] TRIM_RESET     = 8'h80;
    localparam logic [7:0] STATUS_RESET   = 8'h08;
    localparam logic [7:0] MAIN_CFG_RESET = 8'h20;
    localparam logic [7:0] RX_CFG_RESET   = 8'h00;
    localparam logic [7:0] READ_UNMAPPED  = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ST_LIGHT_INT_BIT   = 0;
    localparam int ST_POWER_ON_BIT    = 3;
    localparam int CFG_INT_EN_BIT     = 0;
    localparam int CFG_MODE_LSB       = 2;
    localparam int CFG_MODE_MSB       = 4;
    localparam int CFG_TRIM_SEL_BIT   = 5;
    localparam int RX_GAIN_LSB        = 0;
    localparam int RX_GAIN_MSB        = 1;
    localparam int RX_TIME_LSB        = 2;
    localparam int RX_TIME_MSB        = 3;
    localparam int RESULT_W           = 14;
    localparam logic [2:0] MODE_LIGHT = 3'h1;

    // ------------------------------------------------------------------
    // target addresses (8-bit form, r/w bit zero) and bus figures
    // ------------------------------------------------------------------
    localparam logic [7:0] TARGET_ADDR_LOW  = 8'h94;
    localparam logic [7:0] TARGET_ADDR_HIGH = 8'h96;
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
    localparam int         SCL_MAX_KHZ      = 400;

    // ------------------------------------------------------------------
    // serial engine states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LSIT_IDLE      = 3'b000,
        LSIT_ADDR      = 3'b001,
        LSIT_ADDR_ACK  = 3'b010,
        LSIT_WRITE     = 3'b011,
        LSIT_WRITE_ACK = 3'b100,
        LSIT_READ      = 3'b101,
        LSIT_READ_ACK  = 3'b110
    } lsit_state_t;

endpackage

// ### design/lsit_placeholder_none.sv
// lsit_placeholder_none: intentionally empty compile unit.
// assumes nothing; holds no logic.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### design/lsit_port.sv
// lsit_port: two-wire target port, registers and result path of a light sensor.
// assumes measurement inputs are synchronous to clk; scl/sda/strap are pins,
// oversampled on link_clk, which must run well above 8x the serial clock.
`timescale 1ns/1ps
`default_nettype none

module lsit_port
    import lsit_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                link_clk,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe,
    input  wire logic                address_select_pin,
    input  wire logic [RESULT_W-1:0] green_count,
    input  wire logic [RESULT_W-1:0] ir_count,
    input  wire logic                green_over,
    input  wire logic                ir_over,
    input  wire logic                sample_valid,
    output logic                     int_n,
    output logic [2:0]               sense_mode,
    output logic [1:0]               gain_setting,
    output logic [1:0]               integ_setting,
    output logic [6:0]               green_trim,
    output logic [8:0]               infrared_gain_trim,
    output logic                     trim_select_bar
);

    // ------------------------------------------------------------------
    // core domain: result formation and hand-off toward the link
    // ------------------------------------------------------------------
    logic [2:0]          mode_s1;
    logic [2:0]          mode_s2;
    logic                ack_s1;
    logic                ack_s2;
    logic                req_tog;
    logic [RESULT_W:0]   xfer_data;
    logic                next_req_tog;
    logic [RESULT_W:0]   next_xfer_data;
    logic                ack_tog;
    logic [7:0]          main_cfg;

    // samples arriving while a hand-off is open are dropped; the adc rate is
    // far below the crossing latency, so no buffering is spent here
    always_comb begin
        next_req_tog   = req_tog;
        next_xfer_data = xfer_data;
        if (sample_valid && (req_tog == ack_s2)) begin
            next_req_tog = ~req_tog;
            next_xfer_data[RESULT_W] = green_over | ir_over;
            if (mode_s2 == MODE_LIGHT) begin
                // negative differences clamp to zero rather than wrapping
                if (green_count > ir_count) begin
                    next_xfer_data[RESULT_W-1:0] = green_count - ir_count;
                end else begin
                    next_xfer_data[RESULT_W-1:0] = '0;
                end
            end else begin
                next_xfer_data[RESULT_W-1:0] = green_count;
            end
        end
    end

    // mode is quasi-static config, a two-stage level sync is enough
    always_ff @(posedge clk) begin
        mode_s1 <= main_cfg[CFG_MODE_MSB:CFG_MODE_LSB];
        mode_s2 <= mode_s1;
        ack_s1  <= ack_tog;
        ack_s2  <= ack_s1;
        if (!rst_n) begin
            req_tog   <= 1'b0;
            xfer_data <= '0;
        end else begin
            req_tog   <= next_req_tog;
            xfer_data <= next_xfer_data;
        end
    end

    // ------------------------------------------------------------------
    // link domain: reset and pin synchronisers
    // ------------------------------------------------------------------
    logic lrst_s1;
    logic link_rst_n;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic asel_s1;
    logic asel_s2;
    logic req_s1;
    logic req_s2;
    logic req_s3;

    // oversampling keeps the 400 kHz clock far from the sample rate
    always_ff @(posedge link_clk) begin
        lrst_s1    <= rst_n;
        link_rst_n <= lrst_s1;
        scl_s1     <= scl_i;
        scl_s2     <= scl_s1;
        scl_s3     <= scl_s2;
        sda_s1     <= sda_i;
        sda_s2     <= sda_s1;
        sda_s3     <= sda_s2;
        asel_s1    <= address_select_pin;
        asel_s2    <= asel_s1;
        req_s1     <= req_tog;
        req_s2     <= req_s1;
        req_s3     <= req_s2;
    end

    // ------------------------------------------------------------------
    // link domain: bus conditions
    // ------------------------------------------------------------------
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic [6:0] my_addr;

    // any data edge with clock steady high is a control condition
    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign start_c  = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign stop_c   = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    assign my_addr  = asel_s2 ? TARGET_ADDR_HIGH[7:1] : TARGET_ADDR_LOW[7:1];

    // ------------------------------------------------------------------
    // link domain: engine and register file
    // ------------------------------------------------------------------
    lsit_state_t       state;
    lsit_state_t       next_state;
    logic [3:0]        bit_cnt;
    logic [3:0]        next_bit_cnt;
    logic [7:0]        shift;
    logic [7:0]        next_shift;
    logic [7:0]        tx;
    logic [7:0]        next_tx;
    logic [7:0]        ptr;
    logic [7:0]        next_ptr;
    logic              rw;
    logic              next_rw;
    logic              bus_busy;
    logic              next_bus_busy;
    logic              restart;
    logic              next_restart;
    logic              ptr_loaded;
    logic              next_ptr_loaded;
    logic              reading;
    logic              next_reading;
    logic              nack;
    logic              next_nack;
    logic              next_sda_oe;
    logic [7:0]        status;
    logic [7:0]        next_status;
    logic [7:0]        next_main_cfg;
    logic [7:0]        rx_cfg;
    logic [7:0]        next_rx_cfg;
    logic [7:0]        trim_lo;
    logic [7:0]        next_trim_lo;
    logic [7:0]        trim_hi;
    logic [7:0]        next_trim_hi;
    logic [RESULT_W:0] result;
    logic [RESULT_W:0] next_result;
    logic [RESULT_W:0] stage;
    logic [RESULT_W:0] next_stage;
    logic              pend;
    logic              next_pend;
    logic              next_ack_tog;
    logic              next_int_n;
    logic              clear_status;
    logic              light_set;
    logic [7:0]        fetch_addr;

    // read view of the register map
    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [7:0] v;
        v = READ_UNMAPPED;
        case (a)
            REG_STATUS:     v = status;
            REG_MAIN_CFG:   v = main_cfg;
            REG_RX_CFG:     v = rx_cfg;
            REG_RESULT_HI:  v = {1'b0, result[RESULT_W], result[RESULT_W-1:8]};
            REG_RESULT_LO:  v = result[7:0];
            REG_GREEN_TRIM: v = ~trim_lo;
            REG_IR_TRIM_HI: v = ~trim_hi;
            default:        v = READ_UNMAPPED;
        endcase
        return v;
    endfunction

    always_comb begin
        next_state      = state;
        next_bit_cnt    = bit_cnt;
        next_shift      = shift;
        next_tx         = tx;
        next_ptr        = ptr;
        next_rw         = rw;
        next_bus_busy   = bus_busy;
        next_restart    = restart;
        next_ptr_loaded = ptr_loaded;
        next_reading    = reading;
        next_nack       = nack;
        next_sda_oe     = sda_oe;
        next_main_cfg   = main_cfg;
        next_rx_cfg     = rx_cfg;
        next_trim_lo    = trim_lo;
        next_trim_hi    = trim_hi;
        next_result     = result;
        next_stage      = stage;
        next_pend       = pend;
        next_ack_tog    = ack_tog;
        clear_status    = 1'b0;
        light_set       = 1'b0;
        fetch_addr      = ptr;

        // results wait in the stage while a read is open
        if (pend && !reading) begin
            next_result = stage;
            next_pend   = 1'b0;
            light_set   = stage[RESULT_W] & main_cfg[CFG_INT_EN_BIT];
        end
        // accept a new result word from the core; data is held until acked
        if (req_s2 != req_s3) begin
            next_stage   = xfer_data;
            next_pend    = 1'b1;
            next_ack_tog = req_s2;
        end

        if (stop_c) begin
            next_state    = LSIT_IDLE;
            next_sda_oe   = 1'b0;
            next_reading  = 1'b0;
            next_bus_busy = 1'b0;
        end else if (start_c) begin
            next_state    = LSIT_ADDR;
            next_bit_cnt  = '0;
            next_sda_oe   = 1'b0;
            next_restart  = bus_busy;
            next_bus_busy = 1'b1;
        end else begin
            unique case (state)
                LSIT_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                LSIT_ADDR, LSIT_WRITE: begin
                    if (scl_rise) begin
                        next_shift   = {shift[6:0], sda_s2};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && (bit_cnt == BITS_PER_BYTE)) begin
                        if (state == LSIT_ADDR) begin
                            if (shift[7:1] == my_addr) begin
                                next_sda_oe = 1'b1;
                                next_rw     = shift[0];
                                next_state  = LSIT_ADDR_ACK;
                            end else begin
                                next_state  = LSIT_IDLE;
                            end
                        end else begin
                            next_sda_oe = 1'b1;
                            next_state  = LSIT_WRITE_ACK;
                            if (!ptr_loaded) begin
                                next_ptr        = shift;
                                next_ptr_loaded = 1'b1;
                            end else begin
                                next_ptr = ptr + 8'h01;
                                case (ptr)
                                    REG_MAIN_CFG:   next_main_cfg = shift;
                                    REG_RX_CFG:     next_rx_cfg   = shift;
                                    REG_GREEN_TRIM: next_trim_lo  = shift;
                                    REG_IR_TRIM_HI: next_trim_hi  = shift;
                                    default: ;
                                endcase
                            end
                        end
                    end
                end
                LSIT_ADDR_ACK, LSIT_READ_ACK: begin
                    if (scl_rise && (state == LSIT_READ_ACK)) begin
                        next_nack = sda_s2;
                    end else if (scl_fall) begin
                        next_bit_cnt = '0;
                        if ((state == LSIT_ADDR_ACK) && !rw) begin
                            next_sda_oe     = 1'b0;
                            next_state      = LSIT_WRITE;
                            next_ptr_loaded = 1'b0;
                        end else if ((state == LSIT_READ_ACK) && nack) begin
                            next_sda_oe = 1'b0;
                            next_state  = LSIT_IDLE;
                        end else begin
                            // fresh start resets the pointer, repeated start keeps it
                            if ((state == LSIT_ADDR_ACK) && !restart) begin
                                fetch_addr = REG_STATUS;
                            end
                            next_tx      = rd_byte(fetch_addr);
                            next_sda_oe  = ~next_tx[7];
                            next_ptr     = fetch_addr + 8'h01;
                            next_reading = 1'b1;
                            next_state   = LSIT_READ;
                            clear_status = (fetch_addr == REG_STATUS);
                        end
                    end
                end
                LSIT_READ: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            next_sda_oe = 1'b0;
                            next_state  = LSIT_READ_ACK;
                        end else begin
                            next_tx     = {tx[6:0], 1'b0};
                            next_sda_oe = ~tx[6];
                        end
                    end
                end
                LSIT_WRITE_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe  = 1'b0;
                        next_bit_cnt = '0;
                        next_state   = LSIT_WRITE;
                    end
                end
                default: begin
                    next_state  = LSIT_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end

        // a set arriving with the clearing read survives it
        next_status = clear_status ? 8'h00 : status;
        if (light_set) begin
            next_status[ST_LIGHT_INT_BIT] = 1'b1;
        end
        next_int_n = ~next_status[ST_LIGHT_INT_BIT];
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            state      <= LSIT_IDLE;
            bit_cnt    <= '0;
            shift      <= '0;
            tx         <= '0;
            ptr        <= REG_STATUS;
            rw         <= 1'b0;
            bus_busy   <= 1'b0;
            restart    <= 1'b0;
            ptr_loaded <= 1'b0;
            reading    <= 1'b0;
            nack       <= 1'b0;
            sda_oe     <= 1'b0;
            sda_o      <= 1'b0;
            status     <= STATUS_RESET;
            main_cfg   <= MAIN_CFG_RESET;
            rx_cfg     <= RX_CFG_RESET;
            trim_lo    <= TRIM_RESET;
            trim_hi    <= TRIM_RESET;
            result     <= '0;
            stage      <= '0;
            pend       <= 1'b0;
            ack_tog    <= 1'b0;
            int_n      <= 1'b1;
        end else begin
            state      <= next_state;
            bit_cnt    <= next_bit_cnt;
            shift      <= next_shift;
            tx         <= next_tx;
            ptr        <= next_ptr;
            rw         <= next_rw;
            bus_busy   <= next_bus_busy;
            restart    <= next_restart;
            ptr_loaded <= next_ptr_loaded;
            reading    <= next_reading;
            nack       <= next_nack;
            sda_oe     <= next_sda_oe;
            sda_o      <= 1'b0;                                 // pull low only
            status     <= next_status;
            main_cfg   <= next_main_cfg;
            rx_cfg     <= next_rx_cfg;
            trim_lo    <= next_trim_lo;
            trim_hi    <= next_trim_hi;
            result     <= next_result;
            stage      <= next_stage;
            pend       <= next_pend;
            ack_tog    <= next_ack_tog;
            int_n      <= next_int_n;
        end
    end

    // ------------------------------------------------------------------
    // configuration outputs, straight from the link registers
    // ------------------------------------------------------------------
    assign sense_mode         = main_cfg[CFG_MODE_MSB:CFG_MODE_LSB];
    assign gain_setting       = rx_cfg[RX_GAIN_MSB:RX_GAIN_LSB];
    assign integ_setting      = rx_cfg[RX_TIME_MSB:RX_TIME_LSB];
    assign green_trim         = trim_lo[7:1];
    assign infrared_gain_trim = {trim_hi, trim_lo[0]};
    // custom trims apply only once the host clears this bit
    assign trim_select_bar    = main_cfg[CFG_TRIM_SEL_BIT];

endmodule

`default_nettype wire

// ### sim/light_sensor_i2c_trim_port_tb.sv
// self-checking bench for lsit_port with a bus master model
// assumes strap low, so the port answers at TARGET_ADDR_LOW
`timescale 1ns/1ps
`default_nettype none
module light_sensor_i2c_trim_port_tb;
    import lsit_pkg::*;
    logic       clk, link_clk, rst_n, sv, g_over, sda_oe, int_n, scl, sda_m;
    logic [13:0] g_cnt;
    logic [2:0] mode;
    logic [6:0] g_trim;
    logic [8:0] ir_trim;
    int         fail_count = 0;
    int         n_tests = 0;
    wire logic  sda = ~sda_oe & sda_m; // pull-up wire
    lsit_master m (.scl(scl), .sda_m(sda_m), .sda(sda));
    lsit_port dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe(sda_oe), .address_select_pin(1'b0), .green_count(g_cnt),
        .ir_count(14'h0010), .green_over(g_over), .ir_over(1'b0), .sample_valid(sv),
        .int_n(int_n), .sense_mode(mode), .gain_setting(), .integ_setting(),
        .green_trim(g_trim), .infrared_gain_trim(ir_trim), .trim_select_bar());
    initial begin clk = 1'b0; forever #2 clk = ~clk; end
    initial begin link_clk = 1'b0; #1.3; forever #6 link_clk = ~link_clk; end
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // address, pointer and n data bytes, no stop so a repeated start may follow
    task automatic wr(input logic [7:0] a, d0, d1, input int n);
        logic [7:0] q;
        logic k;
        m.start();
        m.xbyte(TARGET_ADDR_LOW, 1'b1, q, k); chk("addr ack", 9'h0, {8'h0, k});
        m.xbyte(a, 1'b1, q, k); chk("pointer ack", 9'h0, {8'h0, k});
        if (n > 0) begin m.xbyte(d0, 1'b1, q, k); chk("d0 ack", 9'h0, {8'h0, k}); end
        if (n > 1) begin m.xbyte(d1, 1'b1, q, k); chk("d1 ack", 9'h0, {8'h0, k}); end
    endtask
    task automatic rd(output logic [7:0] d0, d1, input int n);
        logic k;
        m.start();
        m.xbyte(TARGET_ADDR_LOW | 8'h01, 1'b1, d0, k); chk("read ack", 9'h0, {8'h0, k});
        m.xbyte(8'hff, n == 1, d0, k);
        if (n > 1) m.xbyte(8'hff, 1'b1, d1, k);
        m.stop();
    endtask
    task automatic t_irq();
        logic [7:0] a, b;
        wr(REG_MAIN_CFG, 8'h05, 8'h00, 1); m.stop();
        chk("mode", 9'h001, {6'h0, mode});
        @(posedge clk); g_cnt <= 14'h3fff; g_over <= 1'b1; sv <= 1'b1;
        @(posedge clk); sv <= 1'b0;
        for (int i = 0; i < 60 && int_n !== 1'b0; i++) @(posedge clk);
        chk("int low", 9'h0, {8'h0, int_n});
        rd(a, b, 1);
        chk("status", 9'h009, {1'b0, a});
        chk("int released", 9'h001, {8'h0, int_n});
        $display("t_irq done");
    endtask
    task automatic t_trim();
        logic [7:0] a, b;
        wr(REG_GREEN_TRIM, 8'h5a, 8'h3c, 2); m.stop();
        chk("green trim", 9'h02d, {2'b0, g_trim});
        chk("ir trim", 9'h078, ir_trim);
        wr(REG_GREEN_TRIM, 8'h00, 8'h00, 0); rd(a, b, 2);
        chk("trim low read", 9'h0a5, {1'b0, a});
        chk("trim high read", 9'h0c3, {1'b0, b});
        $display("t_trim done");
    endtask
    task automatic t_nack();
        logic [7:0] q;
        logic k;
        m.start(); m.xbyte(TARGET_ADDR_HIGH, 1'b1, q, k); m.stop();
        chk("foreign addr nack", 9'h001, {8'h0, k});
        $display("t_nack done");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0; sv = 1'b0; g_over = 1'b0; g_cnt = 14'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        t_irq(); t_trim(); t_nack(); summarize();
    end
    // run needs about 358 us; the limit keeps the run under 100k clk cycles
    initial begin #380us; fail_count++; summarize(); end
endmodule
`default_nettype wire

// ### sim/lsit_master.sv
// two-wire bus master model for the port's serial pins
// assumes the bench wires sda as a pull-up and-ed with the device pull
`timescale 1ns/1ps
`default_nettype none
module lsit_master (
    output logic     scl,
    output logic     sda_m,
    input wire logic sda
);
    localparam time Q = 625ns; // quarter of a 400 kHz period
    initial begin // idle high, clock still between frames
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // data set while low, sampled mid-high
    task automatic bit_x(input logic b, output logic r);
        sda_m = b; #Q scl = 1'b1; #Q r = sda; #Q scl = 1'b0; #Q;
    endtask
    task automatic start(); // also serves as repeated start
        sda_m = 1'b1; #Q scl = 1'b1; #Q sda_m = 1'b0; #Q scl = 1'b0;
    endtask
    task automatic stop();
        sda_m = 1'b0; #Q scl = 1'b1; #Q sda_m = 1'b1; #Q;
    endtask
    // eight bits then ninth clock; reads send ff and give ack in last
    task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic k);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(last, k);
    endtask
endmodule
`default_nettype wire

// ### sim/lsit_port_assertions.sv
// pin-level checks on the light sensor two-wire port
// assumes binding into lsit_port; everything is sampled on link_clk
`timescale 1ns/1ps
`default_nettype none
module lsit_port_assertions (
    input wire logic       clk, link_clk, rst_n, scl_i, sda_o, sda_oe, int_n,
    input wire logic       trim_select_bar,
    input wire logic [2:0] sense_mode,
    input wire logic [6:0] green_trim,
    input wire logic [8:0] infrared_gain_trim
);
    default clocking @(posedge link_clk); endclocking
    // four edges so the two-stage reset sync has landed
    sequence s_rst; !rst_n [*4]; endsequence
    chk_pull_low: assert property (disable iff (!rst_n) sda_o == 1'b0)
        else $error("data pin driven high");
    chk_oe_scl_low: assert property (disable iff (!rst_n) $changed(sda_oe) |-> !scl_i)
        else $error("data pull changed with clock high");
    chk_rst_pins: assert property (s_rst |-> !sda_oe && int_n)
        else $error("pins not released in reset");
    chk_rst_trims: assert property (s_rst |-> green_trim == 7'h40 && infrared_gain_trim == 9'h100)
        else $error("trim reset value wrong");
    chk_rst_factory: assert property (s_rst |-> trim_select_bar)
        else $error("factory trim not selected in reset");
    chk_trim_scl_low: assert property (disable iff (!rst_n)
        $changed({green_trim, infrared_gain_trim}) |-> !scl_i)
        else $error("trim changed with clock high");
    chk_mode_scl_low: assert property (disable iff (!rst_n) $changed(sense_mode) |-> !scl_i)
        else $error("mode changed with clock high");
    chk_int_release: assert property (disable iff (!rst_n) $rose(int_n) |-> !scl_i)
        else $error("interrupt released with clock high");
endmodule
bind lsit_port lsit_port_assertions u_chk (.clk, .link_clk, .rst_n, .scl_i, .sda_o, .sda_oe,
    .int_n, .trim_select_bar, .sense_mode, .green_trim, .infrared_gain_trim);
`default_nettype wire
